// ===== include/odsl_pkg.sv
// Shared constants and decode helpers for the octal DAC serial load link.
package odsl_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int unsigned WORD_BITS = 12;
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned ADDR_MSB  = 11;
  localparam int unsigned ADDR_LSB  = 8;
  localparam int unsigned DATA_MSB  = 7;
  localparam int unsigned LAST_BIT  = 11;

  // ==========================================================================
  // Codes and reset values
  // ==========================================================================
  localparam logic [ADDR_BITS-1:0] NOP_CODE       = 4'h0;
  localparam logic [ADDR_BITS-1:0] CH_FIRST_CODE  = 4'h1;
  localparam logic [ADDR_BITS-1:0] CH_LAST_CODE   = 4'h8;
  localparam logic [DATA_BITS-1:0] PRESET_CODE    = 8'h80;
  localparam logic [WORD_BITS-1:0] SHIFT_RST      = 12'h000;
  localparam logic [3:0]           BIT_LAST_INDEX = 4'hB;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned SYS_CLK_NS   = 40;
  localparam int unsigned LINK_HALF_NS = 80;
  localparam int unsigned LOAD_HIGH_NS = 200;
  localparam int unsigned LOAD_GAP_NS  = 200;
  localparam logic [7:0] LINK_HALF_CYC = 8'((LINK_HALF_NS / SYS_CLK_NS < 1) ? 1 :
                                            LINK_HALF_NS / SYS_CLK_NS);
  localparam logic [7:0] LOAD_HIGH_CYC = 8'((LOAD_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [7:0] LOAD_GAP_CYC  = 8'((LOAD_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  // True when the address selects one of the eight channels.
  function automatic logic odsl_is_channel(input logic [ADDR_BITS-1:0] addr);
    return (addr >= CH_FIRST_CODE) && (addr <= CH_LAST_CODE);
  endfunction

  // Channel index for a channel address; meaningful only when odsl_is_channel holds.
  function automatic logic [2:0] odsl_channel(input logic [ADDR_BITS-1:0] addr);
    logic [ADDR_BITS-1:0] idx;
    idx = addr - CH_FIRST_CODE;
    return idx[2:0];
  endfunction

endpackage

// ===== include/odsl_if.sv
// Four-wire serial link (clock, data in, data out, load) plus preset between the host and the octal DAC device.
`timescale 1ns/1ps
interface odsl_if;
  logic link_clk;
  logic serial_in;
  logic serial_out;
  logic load_strobe;
  logic preset_n;

  modport device (
    input  link_clk,
    input  serial_in,
    input  load_strobe,
    input  preset_n,
    output serial_out
  );

  modport host (
    output link_clk,
    output serial_in,
    output load_strobe,
    output preset_n,
    input  serial_out
  );
endinterface

// ===== hw/odsl_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module odsl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // The first stage feeds only the second; the agreement test looks at stages two and three.
  always_comb begin
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg    <= RST_VAL;
      s2_reg    <= RST_VAL;
      s3_reg    <= RST_VAL;
      level_reg <= RST_VAL;
    end else begin
      s1_reg    <= async_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule // odsl_sync

// ===== hw/odsl_device.sv
// Device end: serial shift register, load decode and eight preset-able DAC registers.
//
// Summary of operation
// - Shift only on rising serial clock edges.
// - Twelve-bit shift register, twelve edges fill it.
// - Eight address codes do nothing on load.
// - Host sends all-zero address for unchanged devices.
// - Load rising edge writes data to addressed channel.
// - Host strobes load between twelfth and thirteenth edge.
// - Serial output is shift register far end.
// - Chains: host shifts every word, one load.
// - Parallel devices: load strobe acts as select.
// - Host clocks the link only when updating.
// - Word is address nibble first, then data byte.
// - Low preset forces all channels to 80 hex.
// - Eight registers; one update leaves others alone.
`timescale 1ns/1ps
module odsl_device #(
  parameter int unsigned NUM_CH = odsl_pkg::NUM_CH
) (
  odsl_if.device                                link,
  input  wire logic                             clk_sys_i,
  input  wire logic                             sys_rst_i,
  output logic [NUM_CH*odsl_pkg::DATA_BITS-1:0] dac_value_o,
  output logic                                  update_o,
  output logic [2:0]                            update_ch_o,
  output logic                                  nop_o,
  output logic [odsl_pkg::WORD_BITS-1:0]        last_word_o,
  output logic                                  preset_active_o
);

  // ==========================================================================
  // Link clock domain: serial shift register
  // ==========================================================================
  logic [odsl_pkg::WORD_BITS-1:0] shift_reg;
  logic [odsl_pkg::WORD_BITS-1:0] shift_next;

  // New bits enter at the low end, so the first bit of a word ends in the
  // address field once twelve edges have passed.
  always_comb begin
    shift_next = {shift_reg[odsl_pkg::WORD_BITS-2:0], link.serial_in};
  end

  // Falling edges of the link clock are not used anywhere in this module.
  always_ff @(posedge link.link_clk or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= odsl_pkg::SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign link.serial_out = shift_reg[odsl_pkg::LAST_BIT];

  // ==========================================================================
  // System clock domain: load strobe and preset synchronisers
  // ==========================================================================
  logic load_level;
  logic preset_level_n;

  odsl_sync #(
    .RST_VAL (1'b0)
  ) u_load_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (link.load_strobe),
    .level_o   (load_level)
  );

  odsl_sync #(
    .RST_VAL (1'b1)
  ) u_preset_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (link.preset_n),
    .level_o   (preset_level_n)
  );

  // ==========================================================================
  // Load edge detector
  // ==========================================================================
  typedef enum logic [1:0] {
    ODSL_LD_IDLE = 2'b01,
    ODSL_LD_HIGH = 2'b10
  } odsl_ld_state_t;

  odsl_ld_state_t ld_state_reg;
  odsl_ld_state_t ld_state_next;
  logic           load_go;

  // One decode per rising strobe edge; a strobe held high never decodes twice.
  always_comb begin
    ld_state_next = ld_state_reg;
    load_go       = 1'b0;
    case (ld_state_reg)
      ODSL_LD_IDLE: begin
        if (load_level) begin
          load_go       = 1'b1;
          ld_state_next = ODSL_LD_HIGH;
        end
      end
      ODSL_LD_HIGH: begin
        if (!load_level) begin
          ld_state_next = ODSL_LD_IDLE;
        end
      end
      default: begin
        ld_state_next = ODSL_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ld_state_reg <= ODSL_LD_IDLE;
    end else begin
      ld_state_reg <= ld_state_next;
    end
  end

  // ==========================================================================
  // Word decode
  // ==========================================================================
  // The shift register is read across domains without a handshake. This is
  // safe only because the host keeps the link clock still from the twelfth
  // edge until the strobe has been seen here; a shorter quiet time may tear
  // the word. No bit count is kept, so an early strobe decodes whatever bits
  // happen to sit in the register and raises no error.
  logic [odsl_pkg::ADDR_BITS-1:0] word_addr;
  logic [odsl_pkg::DATA_BITS-1:0] word_data;
  logic                           word_hit;
  logic [2:0]                     word_ch;

  always_comb begin
    word_addr = shift_reg[odsl_pkg::ADDR_MSB:odsl_pkg::ADDR_LSB];
    word_data = shift_reg[odsl_pkg::DATA_MSB:0];
    word_hit  = odsl_pkg::odsl_is_channel(word_addr);
    word_ch   = odsl_pkg::odsl_channel(word_addr);
  end

  // ==========================================================================
  // DAC registers
  // ==========================================================================
  // The preset pin acts straight on the registers, without waiting for the
  // system clock, so the channels go to half scale even with no clock running.
  logic preset_any;

  assign preset_any = sys_rst_i | ~link.preset_n;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [odsl_pkg::DATA_BITS-1:0] dac_reg;
      logic [odsl_pkg::DATA_BITS-1:0] dac_next;

      always_comb begin
        dac_next = dac_reg;
        if (load_go && word_hit && (word_ch == 3'(g))) begin
          dac_next = word_data;
        end
      end

      always_ff @(posedge clk_sys_i or posedge preset_any) begin
        if (preset_any) begin
          dac_reg <= odsl_pkg::PRESET_CODE;
        end else begin
          dac_reg <= dac_next;
        end
      end

      assign dac_value_o[g*odsl_pkg::DATA_BITS +: odsl_pkg::DATA_BITS] = dac_reg;
    end
  endgenerate

  // ==========================================================================
  // Status towards the user side
  // ==========================================================================
  logic                           update_reg;
  logic                           update_next;
  logic [2:0]                     update_ch_reg;
  logic [2:0]                     update_ch_next;
  logic                           nop_reg;
  logic                           nop_next;
  logic [odsl_pkg::WORD_BITS-1:0] last_word_reg;
  logic [odsl_pkg::WORD_BITS-1:0] last_word_next;

  // A write that coincides with an asserted preset is lost in the registers,
  // yet still reported here; the preset level output lets the user see it.
  always_comb begin
    update_next    = load_go && word_hit;
    nop_next       = load_go && !word_hit;
    update_ch_next = update_ch_reg;
    last_word_next = last_word_reg;
    if (load_go) begin
      last_word_next = shift_reg;
      if (word_hit) begin
        update_ch_next = word_ch;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      update_reg    <= 1'b0;
      update_ch_reg <= 3'h0;
      nop_reg       <= 1'b0;
      last_word_reg <= odsl_pkg::SHIFT_RST;
    end else begin
      update_reg    <= update_next;
      update_ch_reg <= update_ch_next;
      nop_reg       <= nop_next;
      last_word_reg <= last_word_next;
    end
  end

  assign update_o        = update_reg;
  assign update_ch_o     = update_ch_reg;
  assign nop_o           = nop_reg;
  assign last_word_o     = last_word_reg;
  assign preset_active_o = ~preset_level_n;

endmodule // odsl_device

// ===== hw/odsl_host.sv
// Host end: makes the link clock, shifts command words out and pulses the load strobe.
`timescale 1ns/1ps
module odsl_host (
  odsl_if.host                                link,
  input  wire logic                           clk_sys_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           cmd_valid_i,
  output logic                                cmd_ready_o,
  input  wire logic [odsl_pkg::ADDR_BITS-1:0] cmd_addr_i,
  input  wire logic [odsl_pkg::DATA_BITS-1:0] cmd_data_i,
  input  wire logic                           cmd_nop_i,
  input  wire logic                           cmd_load_i,
  input  wire logic                           preset_req_i
);

  // ==========================================================================
  // Shift sequencer
  // ==========================================================================
  typedef enum logic [4:0] {
    ODSL_H_IDLE = 5'b00001,
    ODSL_H_LOW  = 5'b00010,
    ODSL_H_HIGH = 5'b00100,
    ODSL_H_LOAD = 5'b01000,
    ODSL_H_GAP  = 5'b10000
  } odsl_h_state_t;

  odsl_h_state_t                  st_reg;
  odsl_h_state_t                  st_next;
  logic [7:0]                     cnt_reg;
  logic [7:0]                     cnt_next;
  logic [3:0]                     bit_reg;
  logic [3:0]                     bit_next;
  logic [odsl_pkg::WORD_BITS-1:0] sh_reg;
  logic [odsl_pkg::WORD_BITS-1:0] sh_next;
  logic                           load_reg;
  logic                           load_next;
  logic                           sclk_reg;
  logic                           sclk_next;
  logic                           ld_reg;
  logic                           ld_next;
  logic                           pre_reg;

  // The link clock only toggles while a word is shifted and rests low
  // otherwise, which also keeps it still across every strobe.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    load_next = load_reg;
    sclk_next = sclk_reg;
    ld_next   = ld_reg;
    case (st_reg)
      ODSL_H_IDLE: begin
        if (cmd_valid_i) begin
          sh_next   = {cmd_nop_i ? odsl_pkg::NOP_CODE : cmd_addr_i, cmd_data_i};
          load_next = cmd_load_i;
          bit_next  = 4'h0;
          cnt_next  = odsl_pkg::LINK_HALF_CYC - 8'h01;
          st_next   = ODSL_H_LOW;
        end
      end
      ODSL_H_LOW: begin
        if (cnt_reg == 8'h00) begin
          sclk_next = 1'b1;
          cnt_next  = odsl_pkg::LINK_HALF_CYC - 8'h01;
          st_next   = ODSL_H_HIGH;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ODSL_H_HIGH: begin
        if (cnt_reg == 8'h00) begin
          sclk_next = 1'b0;
          bit_next  = bit_reg + 4'h1;
          cnt_next  = odsl_pkg::LINK_HALF_CYC - 8'h01;
          sh_next   = {sh_reg[odsl_pkg::WORD_BITS-2:0], 1'b0};
          if (bit_reg == odsl_pkg::BIT_LAST_INDEX) begin
            if (load_reg) begin
              ld_next  = 1'b1;
              cnt_next = odsl_pkg::LOAD_HIGH_CYC - 8'h01;
              st_next  = ODSL_H_LOAD;
            end else begin
              st_next = ODSL_H_IDLE;
            end
          end else begin
            st_next = ODSL_H_LOW;
          end
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ODSL_H_LOAD: begin
        if (cnt_reg == 8'h00) begin
          ld_next  = 1'b0;
          cnt_next = odsl_pkg::LOAD_GAP_CYC - 8'h01;
          st_next  = ODSL_H_GAP;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ODSL_H_GAP: begin
        if (cnt_reg == 8'h00) begin
          st_next = ODSL_H_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        st_next   = ODSL_H_IDLE;
        sclk_next = 1'b0;
        ld_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg   <= ODSL_H_IDLE;
      cnt_reg  <= 8'h00;
      bit_reg  <= 4'h0;
      sh_reg   <= odsl_pkg::SHIFT_RST;
      load_reg <= 1'b0;
      sclk_reg <= 1'b0;
      ld_reg   <= 1'b0;
      pre_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      load_reg <= load_next;
      sclk_reg <= sclk_next;
      ld_reg   <= ld_next;
      pre_reg  <= preset_req_i;
    end
  end

  assign cmd_ready_o      = (st_reg == ODSL_H_IDLE);
  assign link.link_clk    = sclk_reg;
  assign link.serial_in   = sh_reg[odsl_pkg::LAST_BIT];
  assign link.load_strobe = ld_reg;
  assign link.preset_n    = ~pre_reg;

endmodule // odsl_host

// ===== tb/odsl_link_asserts.sv
// Concurrent checks on the serial link that joins the host end to the device end.
`timescale 1ns/1ps
module odsl_link_asserts (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic link_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic load_strobe
);
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_cnt_next;
  logic       link_q_reg;
  logic [3:0] fill_cnt_reg;
  logic [3:0] fill_cnt_next;

  // The link clock is made from clk_sys, so its rises are seen here without a synchroniser.
  always_comb begin
    rise_cnt_next = rise_cnt_reg;
    if (link_clk && !link_q_reg) begin
      rise_cnt_next = (rise_cnt_reg == 4'hB) ? 4'h0 : rise_cnt_reg + 4'h1;
    end
    fill_cnt_next = (fill_cnt_reg == 4'hC) ? fill_cnt_reg : fill_cnt_reg + 4'h1;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rise_cnt_reg <= 4'h0;
      link_q_reg   <= 1'b0;
    end else begin
      rise_cnt_reg <= rise_cnt_next;
      link_q_reg   <= link_clk;
    end
  end

  // Counts link rises since reset, so the delay check only sees bits shifted after it.
  always_ff @(posedge link_clk or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fill_cnt_reg <= 4'h0;
    end else begin
      fill_cnt_reg <= fill_cnt_next;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_sout_twelve_delay: assert property (@(posedge link_clk) disable iff (sys_rst_i)
    fill_cnt_reg == 4'hC |-> serial_out == $past(serial_in, 12))
    else $error("serial output is not the bit entered twelve rises earlier");
  a_sout_on_rise: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $changed(serial_out) |-> $rose(link_clk))
    else $error("serial output changed without a link clock rise");
  a_data_stable_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    link_clk |-> $stable(serial_in))
    else $error("serial input changed while link clock high");
  a_clock_shape: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(link_clk) |-> link_clk [*2] ##1 !link_clk)
    else $error("link clock high phase has the wrong length");
  a_strobe_word_edge: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(load_strobe) |-> rise_cnt_reg == 4'h0)
    else $error("load strobe not on a twelve bit boundary");
  a_quiet_strobe: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(load_strobe) |-> !link_clk [*8])
    else $error("link clock rose during the load strobe");
  a_strobe_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(load_strobe) |-> load_strobe [*5] ##1 !load_strobe)
    else $error("load strobe width is not five cycles");
  a_quiet_after: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(load_strobe) |-> !link_clk [*6])
    else $error("link clock toggled right after the load strobe");
endmodule // odsl_link_asserts

// ===== tb/octal_dac_serial_load_tb_top.sv
// Testbench top: host and device ends joined by a link, plus a bench-driven device.
`timescale 1ns/1ps
module octal_dac_serial_load_tb_top;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [3:0]  cmd_addr;
  logic [7:0]  cmd_data;
  logic        cmd_nop;
  logic        cmd_load;
  logic        preset_req;
  logic [63:0] dac_a;
  logic [63:0] dac_b;
  logic        upd_a;
  logic [2:0]  upd_ch_a;
  logic        nop_a;
  logic [11:0] word_a;
  logic [11:0] word_b;
  logic        pact_a;
  logic [63:0] model;
  logic [11:0] seen;
  int          mismatches;
  int          num_checks;
  int          cycles;
  int          upd_seen;
  int          nop_seen;
  localparam logic [63:0] ALL_HALF = 64'h8080_8080_8080_8080;

  odsl_if link_a ();
  odsl_if link_b ();

  odsl_host odsl_host_i (.link(link_a.host), .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .cmd_nop_i(cmd_nop), .cmd_load_i(cmd_load),
    .preset_req_i(preset_req));
  odsl_device odsl_device_i (.link(link_a.device), .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .dac_value_o(dac_a), .update_o(upd_a), .update_ch_o(upd_ch_a),
    .nop_o(nop_a), .last_word_o(word_a), .preset_active_o(pact_a));
  // Second device faces the bench, which breaks the host's timing on purpose.
  odsl_device odsl_device_b_i (.link(link_b.device), .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .dac_value_o(dac_b), .update_o(), .update_ch_o(),
    .nop_o(), .last_word_o(word_b), .preset_active_o());
  odsl_link_asserts odsl_link_asserts_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .link_clk(link_a.link_clk), .serial_in(link_a.serial_in),
    .serial_out(link_a.serial_out), .load_strobe(link_a.load_strobe));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (upd_a === 1'b1) upd_seen++;
    if (nop_a === 1'b1) nop_seen++;
    if (cycles == 30000) begin
      $display("Error at %0t: run timed out", $time);
      mismatches++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk(64'(k < 200), 64'h1);
  endtask

  // One host command; the expected channel image follows only words that are loaded.
  task automatic send(input logic [3:0] a, input logic [7:0] d, input logic n,
                      input logic ld);
    @(negedge clk_sys_i);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_addr  = a;
    cmd_data  = d;
    cmd_nop   = n;
    cmd_load  = ld;
    @(negedge clk_sys_i);
    cmd_valid = 1'b0;
    wait_ready();
    if (ld && !n && a >= 4'h1 && a <= 4'h8 && preset_req == 1'b0) begin
      model[(int'(a) - 1) * 8 +: 8] = d;
    end
  endtask

  // Bench link clock runs at 125 ns only inside a frame and stands low otherwise.
  task automatic shift_b(input logic [11:0] w, input int n);
    seen = 12'h000;
    for (int i = 0; i < n; i++) begin
      link_b.serial_in = w[11 - i];
      #62.5;
      seen = {seen[10:0], link_b.serial_out};
      link_b.link_clk = 1'b1;
      #31;
      // A falling-edge sampler would catch this inverted value instead.
      link_b.serial_in = ~w[11 - i];
      #31.5;
      link_b.link_clk = 1'b0;
    end
  endtask

  task automatic strobe_b();
    @(negedge clk_sys_i);
    link_b.load_strobe = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    link_b.load_strobe = 1'b0;
    repeat (6) @(negedge clk_sys_i);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    sys_rst_i = 1'b1;
    {cmd_valid, cmd_nop, cmd_load, preset_req} = 4'h0;
    cmd_addr = 4'h0;
    cmd_data = 8'h00;
    link_b.link_clk = 1'b0;
    link_b.serial_in = 1'b0;
    link_b.load_strobe = 1'b0;
    link_b.preset_n = 1'b1;
    model = ALL_HALF;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk(dac_a, ALL_HALF);
    chk(64'(word_a), 64'h0);
    // Every address code, channel and no-operation alike.
    for (int a = 0; a < 16; a++) begin
      send(4'(a), {4'(a), ~4'(a)}, 1'b0, 1'b1);
      chk(dac_a, model);
      chk(64'(word_a), 64'({4'(a), 4'(a), ~4'(a)}));
      if (a >= 1 && a <= 8) chk(64'(upd_ch_a), 64'(a - 1));
    end
    chk(64'(upd_seen), 64'h8);
    chk(64'(nop_seen), 64'h8);
    send(4'h3, 8'h44, 1'b1, 1'b1);
    chk(64'(word_a), 64'h044);
    chk(dac_a, model);
    send(4'h2, 8'h77, 1'b0, 1'b0);
    send(4'h6, 8'h99, 1'b0, 1'b1);
    chk(dac_a, model);
    preset_req = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk(dac_a, ALL_HALF);
    chk(64'(pact_a), 64'h1);
    send(4'h1, 8'h55, 1'b0, 1'b1);
    chk(dac_a, ALL_HALF);
    preset_req = 1'b0;
    model = ALL_HALF;
    repeat (8) @(negedge clk_sys_i);
    chk(64'(pact_a), 64'h0);
    send(4'h8, 8'h01, 1'b0, 1'b1);
    chk(dac_a, model);
    // Bench-driven device: full word, then a strobe after only eight bits.
    shift_b(12'h3a5, 12);
    strobe_b();
    chk(dac_b, 64'h8080_8080_80a5_8080);
    shift_b(12'h1c3, 8);
    chk(64'(seen), 64'h03a);
    chk(dac_b, 64'h8080_8080_80a5_8080);
    strobe_b();
    chk(64'(word_b), 64'h51c);
    chk(dac_b, 64'h8080_801c_80a5_8080);
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk(dac_a, ALL_HALF);
    model = ALL_HALF;
    send(4'h5, 8'hc3, 1'b0, 1'b1);
    chk(dac_a, model);
    give_verdict();
  end
endmodule // octal_dac_serial_load_tb_top
